// ===== ctp_pkg.sv
// Package for the transmit port configuration register slice.
// Assumes an 8-bit register access port with 8-bit addresses.
package ctp_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CTP_ADDR_TIME_HIGH = 8'h30;
  localparam logic [7:0] CTP_ADDR_TIME_LOW = 8'h31;
  localparam logic [7:0] CTP_ADDR_BANK_SEL = 8'h32;
  localparam logic [7:0] CTP_ADDR_LANE_CTL = 8'h33;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTP_SEL_READ_BIT = 4;
  localparam int CTP_SEL_WR1_BIT = 1;
  localparam int CTP_SEL_WR0_BIT = 0;
  localparam int CTP_CTL_CAL_BIT = 6;
  localparam int CTP_CTL_LANE_HI = 5;
  localparam int CTP_CTL_LANE_LO = 4;
  localparam int CTP_CTL_LP_HI = 3;
  localparam int CTP_CTL_LP_LO = 2;
  localparam int CTP_CTL_CONT_BIT = 1;
  localparam int CTP_CTL_EN_BIT = 0;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [7:0] CTP_SEL_MASK = 8'h13;
  localparam logic [7:0] CTP_CTL_MASK = 8'h7f;
  localparam logic [7:0] CTP_SEL_RESET = 8'h00;
  localparam logic [7:0] CTP_CTL_RESET = 8'h00;

  // ----------------------------------------
  // Forced low-power encodings
  // ----------------------------------------
  localparam logic [1:0] CTP_LP_NORMAL = 2'h0;
  localparam logic [1:0] CTP_LP_DATA = 2'h1;
  localparam logic [1:0] CTP_LP_RSVD = 2'h2;
  localparam logic [1:0] CTP_LP_ALL = 2'h3;

  // Transmitter sequencing states
  typedef enum logic [1:0] {CTP_TX_OFF, CTP_TX_CAL, CTP_TX_RUN} ctp_tx_state_type;
endpackage

// ===== ctp_tx_port.sv
// One transmit port: control copy, field decode and start-up sequencing.
// Assumes the calibration done and packet sent inputs come from the same clock.
`timescale 1ns/10ps
module ctp_tx_port
  import ctp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register write
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  // Transmitter events
  input wire logic cal_done_i,
  input wire logic pkt_sent_i,
  // Control view
  output logic [7:0] ctl_o,
  output logic [2:0] lane_count_o,
  output logic lp_data_o,
  output logic lp_clock_o,
  output logic cal_request_o,
  output logic hs_allow_o,
  output logic clock_cont_o,
  output logic output_en_o
);
  logic [7:0] ctl_reg, ctl_next;
  ctp_tx_state_type state_reg, state_next;
  logic sent_reg, sent_next;
  logic [3:0] lanes_wide;

  // Next control value and sequencing; disabled output restarts the sequence
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_en_i) begin
      ctl_next = wr_data_i & CTP_CTL_MASK; // R15
    end
    state_next = state_reg;
    sent_next = sent_reg;
    case (state_reg)
      CTP_TX_OFF: begin
        sent_next = 1'b0;
        if (ctl_reg[CTP_CTL_EN_BIT]) begin
          state_next = ctl_reg[CTP_CTL_CAL_BIT] ? CTP_TX_CAL : CTP_TX_RUN; // R8
        end
      end
      CTP_TX_CAL: begin
        if (!ctl_reg[CTP_CTL_EN_BIT]) begin
          state_next = CTP_TX_OFF;
        end else if (cal_done_i) begin
          state_next = CTP_TX_RUN; // R8
        end
      end
      CTP_TX_RUN: begin
        if (!ctl_reg[CTP_CTL_EN_BIT]) begin
          state_next = CTP_TX_OFF;
        end else if (pkt_sent_i) begin
          sent_next = 1'b1; // R12
        end
      end
      default: begin
        state_next = CTP_TX_OFF;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctl_reg <= CTP_CTL_RESET;
      state_reg <= CTP_TX_OFF;
      sent_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      state_reg <= state_next;
      sent_reg <= sent_next;
    end
  end

  // Field decode: 00 means four lanes, 11 means one
  assign lanes_wide = 4'h4 - {2'h0, ctl_reg[CTP_CTL_LANE_HI:CTP_CTL_LANE_LO]}; // R10
  assign lane_count_o = lanes_wide[2:0];
  // Reserved low-power code is treated as normal operation
  assign lp_data_o = (ctl_reg[CTP_CTL_LP_HI:CTP_CTL_LP_LO] == CTP_LP_DATA) ||
                     (ctl_reg[CTP_CTL_LP_HI:CTP_CTL_LP_LO] == CTP_LP_ALL); // R11
  assign lp_clock_o = (ctl_reg[CTP_CTL_LP_HI:CTP_CTL_LP_LO] == CTP_LP_ALL); // R11
  assign ctl_o = ctl_reg;
  assign cal_request_o = (state_reg == CTP_TX_CAL); // R8
  assign hs_allow_o = (state_reg == CTP_TX_RUN); // R8
  assign clock_cont_o = ctl_reg[CTP_CTL_CONT_BIT] && sent_reg; // R12
  assign output_en_o = ctl_reg[CTP_CTL_EN_BIT]; // R13
endmodule

// ===== ctp_regs.sv
// Register slice: capture time of receive port 3, bank select, per-port lane control.
// Assumes a byte register port driven by an I2C target on the same clock.
`timescale 1ns/10ps
// ----------------------------------------
// How it works
// R1: Address 0x30 reads the upper byte of port 3 capture time.
// R2: Address 0x31 reads the lower byte of port 3 capture time.
// R3: Bank select bit 4 picks which port's control is read back.
// R4: Port 1 control accepts writes only while bank select bit 1 set.
// R5: Port 0 control accepts writes only while bank select bit 0 set.
// R6: Both enable bits set writes both port copies at once.
// R7: Each port has its own control copy, steered by bank select.
// R8: Calibration enable makes the transmitter calibrate before high-speed data.
// R9: Host must enable calibration at the highest lane rate.
// R10: Lane field 00..11 gives four down to one lanes.
// R11: Low-power field: normal, data lanes LP00, reserved, all lanes LP00.
// R12: Continuous clock starts after the first packet when enabled.
// R13: Host stops forwarding before toggling the output enable bit.
// R14: A read-only status bit shows the port selected for reads.
// R15: Writes with no enable change nothing; reserved bits read zero.
// ----------------------------------------
module ctp_regs
  import ctp_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Captured time of receive port 3
  input wire logic [15:0] port3_capture_time_i,
  // Transmitter events per port
  input wire logic [NUM_PORTS-1:0] cal_done_i,
  input wire logic [NUM_PORTS-1:0] pkt_sent_i,
  // Per-port controls
  output logic [NUM_PORTS*3-1:0] lane_count_o,
  output logic [NUM_PORTS-1:0] lp_data_o,
  output logic [NUM_PORTS-1:0] lp_clock_o,
  output logic [NUM_PORTS-1:0] cal_request_o,
  output logic [NUM_PORTS-1:0] hs_allow_o,
  output logic [NUM_PORTS-1:0] clock_cont_o,
  output logic [NUM_PORTS-1:0] output_en_o,
  // Selected read port status
  output logic read_port_o
);
  logic [7:0] sel_reg, sel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic [7:0] ctl_view [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_wr;
  logic ctl_wr;

  // Control writes reach only ports whose enable bit is set
  assign ctl_wr = reg_wr_i && (reg_addr_i == CTP_ADDR_LANE_CTL);
  assign port_wr[0] = ctl_wr && sel_reg[CTP_SEL_WR0_BIT]; // R5
  assign port_wr[1] = ctl_wr && sel_reg[CTP_SEL_WR1_BIT]; // R4

  // ----------------------------------------
  // Port copies
  // ----------------------------------------
  // One instance per port; both see the same data so a dual write lands together
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : gen_port
      ctp_tx_port u_port (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(port_wr[g]), // R6
        .wr_data_i(reg_wdata_i),
        .cal_done_i(cal_done_i[g]),
        .pkt_sent_i(pkt_sent_i[g]),
        .ctl_o(ctl_view[g]), // R7
        .lane_count_o(lane_count_o[g*3 +: 3]),
        .lp_data_o(lp_data_o[g]),
        .lp_clock_o(lp_clock_o[g]),
        .cal_request_o(cal_request_o[g]),
        .hs_allow_o(hs_allow_o[g]),
        .clock_cont_o(clock_cont_o[g]),
        .output_en_o(output_en_o[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bank select and read path
  // ----------------------------------------
  // Reads are registered so the data lines up with the next byte slot
  always_comb begin
    sel_next = sel_reg;
    if (reg_wr_i && (reg_addr_i == CTP_ADDR_BANK_SEL)) begin
      sel_next = reg_wdata_i & CTP_SEL_MASK; // R15
    end
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    if (reg_rd_i) begin
      hit_next = 1'b1;
      case (reg_addr_i)
        CTP_ADDR_TIME_HIGH: rdata_next = port3_capture_time_i[15:8]; // R1
        CTP_ADDR_TIME_LOW: rdata_next = port3_capture_time_i[7:0]; // R2
        CTP_ADDR_BANK_SEL: rdata_next = sel_reg;
        CTP_ADDR_LANE_CTL: rdata_next = ctl_view[sel_reg[CTP_SEL_READ_BIT]]; // R3
        default: begin
          rdata_next = 8'h00;
          hit_next = 1'b0;
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sel_reg <= CTP_SEL_RESET;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_hit_o = hit_reg;
  assign read_port_o = sel_reg[CTP_SEL_READ_BIT]; // R14
endmodule

// ===== ctp_regs_monitor.sv
// Checker for the transmit port configuration register slice.
// Sees only top ports; mirrors the write enables itself.
`timescale 1ns/10ps
module ctp_regs_monitor
  import ctp_pkg::*;
#(parameter int NUM_PORTS = 2)
(
  // Clock, reset and register port
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  // Capture time and port controls
  input wire logic [15:0] port3_capture_time_i,
  input wire logic [NUM_PORTS*3-1:0] lane_count_o,
  input wire logic [NUM_PORTS-1:0] output_en_o,
  input wire logic read_port_o
);
  // --------------------
  // Shadow and checks
  // --------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic [1:0] wen_reg;
  logic ctl_wr;
  assign ctl_wr = reg_wr_i && reg_addr_i == CTP_ADDR_LANE_CTL;
  // Mirrored because the bank select itself is not a port
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wen_reg <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == CTP_ADDR_BANK_SEL) begin
      wen_reg <= reg_wdata_i[1:0];
    end
  end
  chk_hit_mapped: assert property (reg_rd_i |=> reg_hit_o == (($past(reg_addr_i) >> 2) == 8'h0c))
    else $error("hit flag wrong");
  chk_time_high: assert property (reg_rd_i && reg_addr_i == CTP_ADDR_TIME_HIGH |=>
    {reg_rdata_o, 8'h00} == ($past(port3_capture_time_i) & 16'hff00)) else $error("time high wrong");
  chk_time_low: assert property (reg_rd_i && reg_addr_i == CTP_ADDR_TIME_LOW |=>
    {8'h00, reg_rdata_o} == ($past(port3_capture_time_i) & 16'h00ff)) else $error("time low wrong");
  chk_sel_read: assert property (reg_rd_i && reg_addr_i == CTP_ADDR_BANK_SEL |=>
    (reg_rdata_o & ~CTP_SEL_MASK) == 8'h00 && reg_rdata_o[4] == $past(read_port_o)) else $error("select read wrong");
  chk_read_port: assert property (reg_wr_i && reg_addr_i == CTP_ADDR_BANK_SEL |=>
    read_port_o == $past(reg_wdata_i[4])) else $error("read port wrong");
  chk_port0_write: assert property (ctl_wr && wen_reg[0] |=> output_en_o[0] == $past(reg_wdata_i[0]))
    else $error("port 0 write lost");
  chk_port1_write: assert property (ctl_wr && wen_reg[1] |=> output_en_o[1] == $past(reg_wdata_i[0]))
    else $error("port 1 write lost");
  chk_write_blocked: assert property (ctl_wr && wen_reg == 2'h0 |=> $stable(lane_count_o))
    else $error("blocked write landed");
  cover property (ctl_wr && wen_reg == 2'h3);
  cover property (ctl_wr && wen_reg == 2'h0);
  cover property (reg_rd_i && reg_addr_i == CTP_ADDR_TIME_LOW);
endmodule
bind ctp_regs ctp_regs_monitor #(.NUM_PORTS(NUM_PORTS)) mon_u (.*);

// ===== ctp_regs_tb_top.sv
// Self-checking bench for the transmit port configuration register slice.
// Drives the byte register port directly, 1 ns after each rising edge.
`timescale 1ns/10ps
module ctp_regs_tb_top
  import ctp_pkg::*;
;
  logic mclk_i, reg_hit_o, read_port_o;
  logic reset_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [15:0] port3_capture_time_i = 16'h0000;
  logic [1:0] cal_done_i = 2'h0, pkt_sent_i = 2'h0;
  logic [1:0] lp_data_o, lp_clock_o, cal_request_o, hs_allow_o, clock_cont_o, output_en_o;
  logic [5:0] lane_count_o;
  int errors, compares;
  ctp_regs #(.NUM_PORTS(2)) dut_u (.*);
  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end
  // --------------------
  // Access and compare
  // --------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request stands until the taking edge; the next call replaces it
  task automatic acc(input logic w, r, input logic [7:0] a, d);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(1'h0, 1'h1, a, 8'h00);
    chk("rdata", reg_rdata_o, e);
    chk("hit", reg_hit_o, 8'((a >> 2) == 8'h0c));
  endtask
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset_time();
    chk("lanes", lane_count_o, 8'h24);
    rd(CTP_ADDR_LANE_CTL, 8'h00);
    rd(8'h40, 8'h00);
    port3_capture_time_i = 16'hc35a;
    acc(1'h1, 1'h0, CTP_ADDR_TIME_HIGH, 8'hff);
    rd(CTP_ADDR_TIME_HIGH, 8'hc3);
    rd(CTP_ADDR_TIME_LOW, 8'h5a);
    $display("done reset_time");
  endtask
  // Gating per port, then steering of reads between the copies
  task automatic t_bank();
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'hff);
    rd(CTP_ADDR_BANK_SEL, 8'h13);
    chk("rport", read_port_o, 8'h01);
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h01);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'hb0);
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h02);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h20);
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h10);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h3c);
    chk("lanes", lane_count_o, 8'h11);
    rd(CTP_ADDR_LANE_CTL, 8'h20);
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h00);
    rd(CTP_ADDR_LANE_CTL, 8'h30);
    $display("done bank");
  endtask
  task automatic t_decode();
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h03);
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'(i * 20));
      chk("lanes", lane_count_o, {2'h0, 3'(4 - i), 3'(4 - i)});
      chk("lpdata", lp_data_o, i[0] ? 8'h03 : 8'h00);
      chk("lpclk", lp_clock_o, (i == 3) ? 8'h03 : 8'h00);
    end
    $display("done decode");
  endtask
  task automatic t_seq();
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h01);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h43);
    acc(1'h0, 1'h0, 8'h00, 8'h00);
    chk("cal", {cal_request_o, hs_allow_o}, 8'h04);
    cal_done_i = 2'h1;
    acc(1'h0, 1'h0, 8'h00, 8'h00);
    cal_done_i = 2'h0;
    chk("run", {cal_request_o, hs_allow_o, clock_cont_o}, 8'h04);
    pkt_sent_i = 2'h1;
    acc(1'h0, 1'h0, 8'h00, 8'h00);
    pkt_sent_i = 2'h0;
    chk("cont", clock_cont_o, 8'h01);
    // Disable then re-enable without calibration: restart must skip the calibration state
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h00);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h03);
    acc(1'h0, 1'h0, 8'h00, 8'h00);
    chk("nocal", {cal_request_o, hs_allow_o, output_en_o}, 8'h05);
    chk("contoff", clock_cont_o, 8'h00);
    // Port 1 alone enabled, so its own copy must start while port 0 keeps running
    acc(1'h1, 1'h0, CTP_ADDR_BANK_SEL, 8'h02);
    acc(1'h1, 1'h0, CTP_ADDR_LANE_CTL, 8'h01);
    acc(1'h0, 1'h0, 8'h00, 8'h00);
    chk("port1", {hs_allow_o, output_en_o}, 8'h0f);
    $display("done seq");
  endtask
  initial begin
    #20000;
    errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    #1;
    reset_n_i = 1'h1;
    t_reset_time();
    t_bank();
    t_decode();
    t_seq();
    results();
  end
endmodule
